/* File: dv/testbench.sv */
// Self-checking bench for the telemetry register bank.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct {logic [15:0] val; logic nack; bit dec;} tpm_note_t;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic go = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [7:0] pg = 8'h00;
  logic rd_req;
  logic rd_valid_o;
  logic rd_nack_o;
  logic [7:0] rd_cmd;
  logic [7:0] rd_page;
  logic [15:0] rd_data_o;
  logic clear_i = 1'b0;
  logic [7:0] clear_page_i = 8'h00;
  logic [1:0] ch_on_i = 2'h0;
  logic [1:0] tsense_ok_i = 2'h3;
  logic [1:0] iin_range_i = 2'h0;
  logic [8:0] vld = 9'h000;
  logic [15:0] vin_i = 16'h0000;
  logic [15:0] iin_i = 16'h0000;
  logic [15:0] tint_i = 16'h0000;
  logic [1:0][15:0] vout_i = 32'h00000000;
  logic [1:0][15:0] iout_i = 32'h00000000;
  logic [1:0][15:0] sense_i = 32'h00000000;
  logic [1:0][15:0] text_i = 32'h00000000;
  logic [23:0] trk [12] = '{24'hc47c00, 24'hc57bff, 24'hc67c00, 24'hc77bff, 24'hde7c00,
    24'hfc7bff, 24'hd77c00, 24'hd87bff, 24'hddf800, 24'hfbffff, 24'hdf7c00, 24'hfd7bff};
  // Each entry: current word, sense word, fine current, sense magnitude.
  logic [63:0] fin [4] = '{64'h0001fffb01900005, 64'h07ff8000fe708000,
    64'h3bff00077fff0007, 64'h3c01000080000000};
  tpm_note_t notes [$];
  tpm_note_t note;
  int miscompares = 0;
  int comparisons = 0;

  tpm_host u_host (.clock_i(clock_i), .go_i(go), .cmd_i(cmd), .page_i(pg),
    .rd_req_o(rd_req), .rd_cmd_o(rd_cmd), .rd_page_o(rd_page));
  tpm_regs u_dut (.clock_i(clock_i), .srst_i(srst_i), .rd_req_i(rd_req), .rd_cmd_i(rd_cmd),
    .page_i(rd_page), .rd_valid_o(rd_valid_o), .rd_nack_o(rd_nack_o), .rd_data_o(rd_data_o),
    .clear_i(clear_i), .clear_page_i(clear_page_i), .ch_on_i(ch_on_i), .vin_valid_i(vld[0]),
    .vin_i(vin_i), .iin_valid_i(vld[1]), .iin_i(iin_i), .iin_range_i(iin_range_i),
    .tint_valid_i(vld[2]), .tint_i(tint_i), .vout_valid_i(vld[4:3]), .vout_i(vout_i),
    .iout_valid_i(vld[6:5]), .iout_i(iout_i), .sense_i(sense_i), .text_valid_i(vld[8:7]),
    .text_i(text_i), .tsense_ok_i(tsense_ok_i));

  initial forever #5 clock_i = ~clock_i;

  // ********************
  // Checking
  // ********************
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic test_done;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  // Power words are judged by value, since the mantissa scaling is the design's choice.
  function automatic real l11(input logic [15:0] w);
    return $itor($signed(w[10:0])) * (2.0 ** $signed(w[15:11]));
  endfunction : l11

  always @(posedge clock_i)
    if (rd_valid_o === 1'b1)
    begin
      if (notes.size() == 0)
        check(16'h0001, 16'h0000);
      else
      begin
        note = notes.pop_front();
        check({15'h0000, rd_nack_o}, {15'h0000, note.nack});
        check(note.dec && !$isunknown(rd_data_o) ? 16'(int'(l11(rd_data_o))) : rd_data_o,
          note.val);
      end
    end

  // ********************
  // Drivers
  // ********************
  task automatic rd(input logic [7:0] c, input logic [7:0] p, input logic [15:0] v,
    input logic n = 1'b0, input bit d = 1'b0);
    notes.push_back('{v, n, d});
    @(posedge clock_i);
    go <= 1'b1;
    cmd <= c;
    pg <= p;
  endtask : rd

  task automatic cv(input int k, input int ch, input logic [15:0] v, input logic [15:0] s);
    @(posedge clock_i);
    go <= 1'b0;
    case (k)
      0: vin_i <= v;
      1: iin_i <= v;
      2: tint_i <= v;
      3: vout_i[ch] <= v;
      4: iout_i[ch] <= v;
      default: text_i[ch] <= v;
    endcase
    if (k == 4)
      sense_i[ch] <= s;
    vld[(k < 3) ? k : 2 * k - 3 + ch] <= 1'b1;
    @(posedge clock_i);
    vld <= 9'h000;
  endtask : cv

  task automatic cvr(input int k, input int ch, input logic [7:0] c, input logic [15:0] v);
    cv(k, ch, v, ~v);
    rd(c, 8'(ch), v);
  endtask : cvr

  task automatic drain;
    int i;
    @(posedge clock_i);
    go <= 1'b0;
    for (i = 0; i < 50 && notes.size() != 0; i++)
      @(posedge clock_i);
    if (notes.size() != 0)
    begin
      miscompares++;
      test_done;
    end
  endtask : drain

  task automatic clr(input logic [7:0] p);
    drain;
    clear_i <= 1'b1;
    clear_page_i <= p;
    @(posedge clock_i);
    clear_i <= 1'b0;
  endtask : clr

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    logic [15:0] r;
    int i;
    int c;
    void'($urandom(86));
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    for (c = 0; c < 2; c++)
      for (i = 0; i < 12; i++)
        if (i < 6)
          rd(trk[i][23:16], 8'(c), trk[i][15:0]);
        else
          rd(trk[i][23:16], 8'(c), trk[i][15:0]);
    rd(8'h8b, 8'h02, 16'h0000, 1'b1);
    rd(8'h00, 8'h00, 16'h0000, 1'b1);
    drain;
    iin_range_i <= 2'($urandom_range(3));
    cvr(0, 0, 8'h88, 16'($urandom));
    rd(8'h88, 8'h05, vin_i);
    r = 16'($urandom);
    cv(1, 0, r, 16'h0000);
    rd(8'h89, 8'h01, {r[15:11] - 5'(iin_range_i), r[10:0]});
    cvr(2, 1, 8'h8e, 16'($urandom));
    for (c = 0; c < 2; c++)
    begin
      cvr(3, c, 8'h8b, 16'($urandom));
      cvr(4, c, 8'h8c, 16'($urandom));
      cvr(5, c, 8'h8d, 16'($urandom));
    end
    drain;
    // A failed diode on channel 0 only; channel 1 keeps its own reading.
    tsense_ok_i <= 2'h2;
    cv(2, 0, 16'h0123, 16'h0000);
    rd(8'h8d, 8'h01, text_i[1]);
    cv(5, 0, 16'h0456, 16'h0000);
    rd(8'h8d, 8'h00, 16'h0123);
    for (i = 0; i < 4; i++)
    begin
      cv(4, 0, fin[i][63:48], fin[i][47:32]);
      rd(8'hbb, 8'h00, fin[i][31:16]);
      rd(8'hfa, 8'h00, fin[i][15:0]);
    end
    drain;
    iin_range_i <= 2'h0;
    cv(1, 0, 16'h0003, 16'h0000);
    cv(0, 0, 16'h0002, 16'h0000);
    cv(3, 0, 16'h4000, 16'h0000);
    cv(4, 0, 16'h0003, 16'h0000);
    rd(8'h97, 8'h00, 16'h0006, 1'b0, 1'b1);
    rd(8'h96, 8'h00, 16'h0006, 1'b0, 1'b1);
    clr(8'hff);
    rd(8'hde, 8'h00, 16'h7c00);
    rd(8'hfc, 8'h00, 16'h7bff);
    cv(0, 0, 16'h0010, 16'h0000);
    cv(0, 0, 16'hf810, 16'h0000);
    cv(3, 1, 16'h4000, 16'h0000);
    rd(8'hde, 8'h00, 16'h0010);
    rd(8'hfc, 8'h00, 16'hf810);
    clr(8'h00);
    rd(8'hdd, 8'h01, 16'h4000);
    rd(8'hde, 8'h00, 16'h7c00);
    cv(0, 0, 16'h0010, 16'h0000);
    cv(4, 1, 16'h0005, 16'h0000);
    drain;
    ch_on_i <= 2'h2;
    rd(8'hde, 8'h00, 16'h7c00);
    rd(8'hdd, 8'h01, 16'hf800);
    rd(8'hd7, 8'h01, 16'h7c00);
    rd(8'hfb, 8'h01, 16'hffff);
    rd(8'hd8, 8'h01, 16'h7bff);
    drain;
    // A second reset in mid-run must restore live words and preloads alike.
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    rd(8'h8b, 8'h00, 16'h0000);
    rd(8'hdd, 8'h00, 16'hf800);
    rd(8'h88, 8'h00, 16'h0000);
    drain;
    test_done;
  end
endmodule : testbench
`default_nettype wire

/* File: dv/tpm_host.sv */
// Host model that issues read-word requests to the telemetry bank.
`timescale 1ns/1ns
`default_nettype none
module tpm_host (
  input wire logic clock_i,
  input wire logic go_i,
  input wire logic [7:0] cmd_i,
  input wire logic [7:0] page_i,
  output logic rd_req_o,
  output logic [7:0] rd_cmd_o,
  output logic [7:0] rd_page_o
);
  // ********************
  // Request issue
  // ********************
  // Outside a request the code and page invert, so no stale value looks valid.
  always_ff @(posedge clock_i)
  begin
    rd_req_o <= go_i;
    rd_cmd_o <= go_i ? cmd_i : ~rd_cmd_o;
    rd_page_o <= go_i ? page_i : ~rd_page_o;
  end
endmodule : tpm_host
`default_nettype wire

/* File: hdl/tpm_regs.sv */
// Telemetry word bank with peak and minimum trackers, read by command code.
`timescale 1ns/1ns
`default_nettype none
module tpm_regs (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic rd_req_i,
  input wire logic [7:0] rd_cmd_i,
  input wire logic [7:0] page_i,
  output logic rd_valid_o,
  output logic rd_nack_o,
  output logic [15:0] rd_data_o,
  input wire logic clear_i,
  input wire logic [7:0] clear_page_i,
  input wire logic [1:0] ch_on_i,
  input wire logic vin_valid_i,
  input wire logic [15:0] vin_i,
  input wire logic iin_valid_i,
  input wire logic [15:0] iin_i,
  input wire logic [1:0] iin_range_i,
  input wire logic tint_valid_i,
  input wire logic [15:0] tint_i,
  input wire logic [1:0] vout_valid_i,
  input wire logic [1:0][15:0] vout_i,
  input wire logic [1:0] iout_valid_i,
  input wire logic [1:0][15:0] iout_i,
  input wire logic [1:0][15:0] sense_i,
  input wire logic [1:0] text_valid_i,
  input wire logic [1:0][15:0] text_i,
  input wire logic [1:0] tsense_ok_i
);
  // ****************************************************************
  // Arithmetic helpers
  // ****************************************************************
  function automatic logic [15:0] l11_pack(
    input logic signed [47:0] p,
    input logic signed [7:0] e
  );
    logic signed [47:0] m;
    logic signed [7:0] x;
    m = p;
    x = e;
    for (int i = 0; i < 40; i++)
    begin
      if (m > 48'sd1023 || m < -48'sd1024)
      begin
        m = m >>> 1;
        x = x + 8'sd1;
      end
    end
    l11_pack = {x[4:0], m[10:0]};
  endfunction : l11_pack

  function automatic logic [15:0] fine_word(input logic [15:0] w);
    logic signed [47:0] c;
    c = 48'(signed'(w[10:0])) * tpm_pkg::FINE_PER_AMP;
    if (w[15])
      c = c >>> (6'h20 - {1'b0, w[15:11]});
    else
      c = c <<< w[14:11];
    if (c > tpm_pkg::FINE_POS) // [RULE_10]
      fine_word = 16'h7fff;
    else if (c < tpm_pkg::FINE_NEG)
      fine_word = 16'h8000;
    else
      fine_word = c[15:0]; // [RULE_09]
  endfunction : fine_word

  function automatic logic signed [7:0] l11_exp(input logic [15:0] w);
    l11_exp = 8'(signed'(w[15:tpm_pkg::L11_EXP_LSB]));
  endfunction : l11_exp

  // ****************************************************************
  // Input side live words
  // ****************************************************************
  logic [15:0] vin_q;
  logic [15:0] iin_q;
  logic [15:0] pin_q;
  logic [15:0] pin_d;
  logic [15:0] tint_q;
  logic pin_upd_q;
  logic [15:0] iin_scaled;

  // Each range step halves the weight of one raw count.
  assign iin_scaled = {iin_i[15:11] - {3'h0, iin_range_i}, iin_i[10:0]};

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      vin_q <= 16'h0000;
      iin_q <= 16'h0000;
      tint_q <= 16'h0000;
    end
    else
    begin
      if (vin_valid_i)
        vin_q <= vin_i; // [RULE_01]
      if (iin_valid_i)
        iin_q <= iin_scaled; // [RULE_02]
      if (tint_valid_i)
        tint_q <= tint_i; // [RULE_07]
    end
  end

  // Power follows one cycle after either factor lands, so it uses both newest words.
  assign pin_d = l11_pack(
    48'(signed'(vin_q[10:0])) * 48'(signed'(iin_q[10:0])),
    l11_exp(vin_q) + l11_exp(iin_q)); // [RULE_03]

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      pin_upd_q <= 1'b0;
      pin_q <= 16'h0000;
    end
    else
    begin
      pin_upd_q <= vin_valid_i | iin_valid_i;
      if (pin_upd_q)
        pin_q <= pin_d;
    end
  end

  // ****************************************************************
  // Preload events
  // ****************************************************************
  logic [1:0] on_prev_q;
  logic [1:0] ch_rise;
  logic in_pre;
  logic [1:0] ch_pre;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      on_prev_q <= 2'h0;
    else
      on_prev_q <= ch_on_i;
  end

  assign ch_rise = ch_on_i & ~on_prev_q;
  assign in_pre = clear_i | (|ch_rise);

  // ****************************************************************
  // Input trackers
  // ****************************************************************
  logic [15:0] iin_max;
  logic [15:0] iin_low;
  logic [15:0] pin_max;
  logic [15:0] pin_low;
  logic [15:0] vin_max;
  logic [15:0] vin_low;

  tpm_track #(.IS_MAX(1'b1), .IS_L16(1'b0), .PRELOAD(tpm_pkg::L11_MAX_RST)) u_iin_max (
    .clock_i(clock_i), .srst_i(srst_i), .preload_i(in_pre), // [RULE_13]
    .sample_valid_i(iin_valid_i), .sample_i(iin_scaled), .value_o(iin_max));
  tpm_track #(.IS_MAX(1'b0), .IS_L16(1'b0), .PRELOAD(tpm_pkg::L11_LOW_RST)) u_iin_low (
    .clock_i(clock_i), .srst_i(srst_i), .preload_i(in_pre), // [RULE_14]
    .sample_valid_i(iin_valid_i), .sample_i(iin_scaled), .value_o(iin_low));
  tpm_track #(.IS_MAX(1'b1), .IS_L16(1'b0), .PRELOAD(tpm_pkg::L11_MAX_RST)) u_pin_max (
    .clock_i(clock_i), .srst_i(srst_i), .preload_i(in_pre), // [RULE_15]
    .sample_valid_i(pin_upd_q), .sample_i(pin_d), .value_o(pin_max));
  tpm_track #(.IS_MAX(1'b0), .IS_L16(1'b0), .PRELOAD(tpm_pkg::L11_LOW_RST)) u_pin_low (
    .clock_i(clock_i), .srst_i(srst_i), .preload_i(in_pre), // [RULE_16]
    .sample_valid_i(pin_upd_q), .sample_i(pin_d), .value_o(pin_low));
  tpm_track #(.IS_MAX(1'b1), .IS_L16(1'b0), .PRELOAD(tpm_pkg::L11_MAX_RST)) u_vin_max (
    .clock_i(clock_i), .srst_i(srst_i), .preload_i(in_pre), // [RULE_17]
    .sample_valid_i(vin_valid_i), .sample_i(vin_i), .value_o(vin_max));
  tpm_track #(.IS_MAX(1'b0), .IS_L16(1'b0), .PRELOAD(tpm_pkg::L11_LOW_RST)) u_vin_low (
    .clock_i(clock_i), .srst_i(srst_i), .preload_i(in_pre), // [RULE_18]
    .sample_valid_i(vin_valid_i), .sample_i(vin_i), .value_o(vin_low));

  // ****************************************************************
  // Per-channel words and trackers
  // ****************************************************************
  logic [1:0][15:0] vout_q;
  logic [1:0][15:0] iout_q;
  logic [1:0][15:0] temp_q;
  logic [1:0][15:0] pout_q;
  logic [1:0][15:0] fine_q;
  logic [1:0][15:0] sense_q;
  logic [1:0][15:0] temp_sel;
  logic [1:0][15:0] pout_d;
  logic [1:0] pout_upd_q;
  logic [1:0][15:0] vout_max;
  logic [1:0][15:0] vout_low;
  logic [1:0][15:0] iout_max;
  logic [1:0][15:0] iout_low;
  logic [1:0][15:0] temp_max;
  logic [1:0][15:0] temp_low;

  for (genvar c = 0; c < tpm_pkg::NUM_CH; c++)
  begin : g_ch
    assign ch_pre[c] = ch_rise[c] | (clear_i & ((clear_page_i == 8'(c))
      | (clear_page_i == tpm_pkg::PAGE_ALL)));
    assign temp_sel[c] = tsense_ok_i[c] ? text_i[c] : tint_q; // [RULE_06]
    assign pout_d[c] = l11_pack(
      signed'({32'h0, vout_q[c]}) * 48'(signed'(iout_q[c][10:0])),
      tpm_pkg::VOUT_EXP + l11_exp(iout_q[c])); // [RULE_08]

    always_ff @(posedge clock_i)
    begin
      if (srst_i)
      begin
        vout_q[c] <= 16'h0000;
        iout_q[c] <= 16'h0000;
        temp_q[c] <= 16'h0000;
        fine_q[c] <= 16'h0000;
        sense_q[c] <= 16'h0000;
        pout_q[c] <= 16'h0000;
        pout_upd_q[c] <= 1'b0;
      end
      else
      begin
        pout_upd_q[c] <= vout_valid_i[c] | iout_valid_i[c];
        if (pout_upd_q[c])
          pout_q[c] <= pout_d[c];
        if (vout_valid_i[c])
          vout_q[c] <= vout_i[c]; // [RULE_04]
        if (text_valid_i[c])
          temp_q[c] <= temp_sel[c]; // [RULE_06]
        if (iout_valid_i[c])
        begin
          iout_q[c] <= iout_i[c]; // [RULE_05]
          fine_q[c] <= fine_word(iout_i[c]); // [RULE_09]
          // No compensation here: the count is the front end's raw magnitude.
          sense_q[c] <= sense_i[c][15] ? 16'(-sense_i[c]) : sense_i[c]; // [RULE_12] [RULE_11]
        end
      end
    end

    tpm_track #(.IS_MAX(1'b1), .IS_L16(1'b1), .PRELOAD(tpm_pkg::L16_MAX_RST)) u_vmax (
      .clock_i(clock_i), .srst_i(srst_i), .preload_i(ch_pre[c]), // [RULE_19]
      .sample_valid_i(vout_valid_i[c]), .sample_i(vout_i[c]), .value_o(vout_max[c]));
    tpm_track #(.IS_MAX(1'b0), .IS_L16(1'b1), .PRELOAD(tpm_pkg::L16_LOW_RST)) u_vlow (
      .clock_i(clock_i), .srst_i(srst_i), .preload_i(ch_pre[c]), // [RULE_22]
      .sample_valid_i(vout_valid_i[c]), .sample_i(vout_i[c]), .value_o(vout_low[c]));
    tpm_track #(.IS_MAX(1'b1), .IS_L16(1'b0), .PRELOAD(tpm_pkg::L11_MAX_RST)) u_imax (
      .clock_i(clock_i), .srst_i(srst_i), .preload_i(ch_pre[c]), // [RULE_20]
      .sample_valid_i(iout_valid_i[c]), .sample_i(iout_i[c]), .value_o(iout_max[c]));
    tpm_track #(.IS_MAX(1'b0), .IS_L16(1'b0), .PRELOAD(tpm_pkg::L11_LOW_RST)) u_ilow (
      .clock_i(clock_i), .srst_i(srst_i), .preload_i(ch_pre[c]), // [RULE_23]
      .sample_valid_i(iout_valid_i[c]), .sample_i(iout_i[c]), .value_o(iout_low[c]));
    tpm_track #(.IS_MAX(1'b1), .IS_L16(1'b0), .PRELOAD(tpm_pkg::L11_MAX_RST)) u_tmax (
      .clock_i(clock_i), .srst_i(srst_i), .preload_i(ch_pre[c]), // [RULE_21]
      .sample_valid_i(text_valid_i[c]), .sample_i(temp_sel[c]), .value_o(temp_max[c]));
    tpm_track #(.IS_MAX(1'b0), .IS_L16(1'b0), .PRELOAD(tpm_pkg::L11_LOW_RST)) u_tlow (
      .clock_i(clock_i), .srst_i(srst_i), .preload_i(ch_pre[c]),
      .sample_valid_i(text_valid_i[c]), .sample_i(temp_sel[c]), .value_o(temp_low[c]));
  end

  // ****************************************************************
  // Read decode
  // ****************************************************************
  logic [15:0] rd_d;
  logic nack_d;
  logic pg_ok;
  logic ch;
  logic unpaged;

  assign ch = page_i[0];
  // A paged word read with no single channel selected is refused.
  assign pg_ok = page_i < 8'(tpm_pkg::NUM_CH); // [RULE_25]
  // Input voltage, its peak and minimum, and junction temperature answer whatever page is selected.
  assign unpaged = (rd_cmd_i == tpm_pkg::CMD_VIN) || (rd_cmd_i == tpm_pkg::CMD_TINT)
    || (rd_cmd_i == tpm_pkg::CMD_VIN_MAX) || (rd_cmd_i == tpm_pkg::CMD_VIN_LOW);

  always_comb
  begin
    rd_d = 16'h0000;
    nack_d = ~pg_ok && !unpaged;
    case (rd_cmd_i)
      tpm_pkg::CMD_VIN: rd_d = vin_q; // [RULE_01]
      tpm_pkg::CMD_TINT: rd_d = tint_q;
      tpm_pkg::CMD_VIN_MAX: rd_d = vin_max;
      tpm_pkg::CMD_VIN_LOW: rd_d = vin_low;
      tpm_pkg::CMD_IIN: rd_d = iin_q;
      tpm_pkg::CMD_PIN: rd_d = pin_q;
      tpm_pkg::CMD_IIN_MAX: rd_d = iin_max;
      tpm_pkg::CMD_IIN_LOW: rd_d = iin_low;
      tpm_pkg::CMD_PIN_MAX: rd_d = pin_max;
      tpm_pkg::CMD_PIN_LOW: rd_d = pin_low;
      tpm_pkg::CMD_VOUT: rd_d = vout_q[ch];
      tpm_pkg::CMD_IOUT: rd_d = iout_q[ch];
      tpm_pkg::CMD_TEXT: rd_d = temp_q[ch];
      tpm_pkg::CMD_POUT: rd_d = pout_q[ch];
      tpm_pkg::CMD_IOUT_FINE: rd_d = fine_q[ch];
      tpm_pkg::CMD_SENSE: rd_d = sense_q[ch];
      tpm_pkg::CMD_VOUT_MAX: rd_d = vout_max[ch];
      tpm_pkg::CMD_VOUT_LOW: rd_d = vout_low[ch];
      tpm_pkg::CMD_IOUT_MAX: rd_d = iout_max[ch];
      tpm_pkg::CMD_IOUT_LOW: rd_d = iout_low[ch];
      tpm_pkg::CMD_TEXT_MAX: rd_d = temp_max[ch];
      tpm_pkg::CMD_TEXT_LOW: rd_d = temp_low[ch];
      default: nack_d = 1'b1;
    endcase
    if (nack_d)
      rd_d = 16'h0000;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      rd_valid_o <= 1'b0;
      rd_nack_o <= 1'b0;
      rd_data_o <= 16'h0000;
    end
    else
    begin
      rd_valid_o <= rd_req_i;
      rd_nack_o <= rd_req_i & nack_d;
      if (rd_req_i)
        rd_data_o <= rd_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_vin_read: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE_01]
    rd_req_i && rd_cmd_i == tpm_pkg::CMD_VIN |=> rd_valid_o && !rd_nack_o
    && rd_data_o == $past(vin_q))
    else $error("input voltage read mismatch");
  chk_pin_follow: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE_03]
    vin_valid_i ##1 !vin_valid_i && !iin_valid_i |=> pin_q == $past(pin_d))
    else $error("input power not refreshed");
  chk_iin_peak_pre: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE_13]
    clear_i |=> iin_max == tpm_pkg::L11_MAX_RST)
    else $error("input current peak not preloaded");
  chk_pin_low_pre: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE_16]
    $rose(ch_on_i[1]) |=> pin_low == tpm_pkg::L11_LOW_RST)
    else $error("input power minimum not preloaded");
  chk_vout_max_pre: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE_19]
    clear_i && clear_page_i == 8'h00 |=> vout_max[0] == tpm_pkg::L16_MAX_RST)
    else $error("output voltage peak not preloaded");
  chk_vout_low_keep: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE_22]
    clear_i && clear_page_i == 8'h00 && !ch_rise[1] && !vout_valid_i[1]
    |=> vout_low[1] == $past(vout_low[1]))
    else $error("other page minimum disturbed");
  chk_temp_subst: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE_06]
    text_valid_i[0] && !tsense_ok_i[0] |=> temp_q[0] == $past(tint_q))
    else $error("junction temperature not substituted");
  chk_sense_abs: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE_12]
    iout_valid_i[1] |=> !$past(sense_i[1][15]) || sense_q[1] == 16'(-$past(sense_i[1])))
    else $error("sense magnitude wrong");
  chk_fine_sat: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE_10]
    iout_valid_i[0] && iout_i[0] == 16'h3bff |=> fine_q[0] == 16'h7fff)
    else $error("alternate current not saturated");
  chk_bad_page: assert property (@(posedge clock_i) disable iff (srst_i) // [RULE_25]
    rd_req_i && rd_cmd_i == tpm_pkg::CMD_VOUT && page_i >= 8'h02 |=> rd_nack_o
    && rd_data_o == 16'h0000)
    else $error("bad page not refused");
endmodule : tpm_regs
`default_nettype wire

/* File: hdl/tpm_track.sv */
// Peak or minimum tracker for one telemetry quantity.
`timescale 1ns/1ns
`default_nettype none
module tpm_track #(
  parameter bit IS_MAX = 1'b1,
  parameter bit IS_L16 = 1'b0,
  parameter logic [15:0] PRELOAD = 16'h0000
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic preload_i,
  input wire logic sample_valid_i,
  input wire logic [15:0] sample_i,
  output logic [15:0] value_o
);
  // Raw codes do not order like numbers, so both sides are decoded first.
  function automatic logic signed [47:0] num(input logic [15:0] w);
    logic [5:0] sh;
    sh = {w[15], w[15:11]} + 6'h10;
    if (IS_L16)
      num = signed'({32'h0, w});
    else
      num = 48'(signed'(w[10:0])) <<< sh;
  endfunction : num

  logic hit;
  logic empty_q;
  assign hit = IS_MAX ? (num(sample_i) > num(value_o)) : (num(sample_i) < num(value_o));

  // A preload stands for nothing seen yet, not for its raw code: the linear-11 peak
  // preload 0x7C00 decodes to zero, so the first sample after any preload always lands.
  always_ff @(posedge clock_i)
  begin
    if (srst_i || preload_i)
      empty_q <= 1'b1;
    else if (sample_valid_i)
      empty_q <= 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i || preload_i)
      value_o <= PRELOAD;
    else if (sample_valid_i && (hit || empty_q)) // [RULE_24]
      value_o <= sample_i;
  end
endmodule : tpm_track
`default_nettype wire

/* File: pkg/tpm_pkg.sv */
// Package of command codes, preload values and scaling for the telemetry bank.
// Contract
// RULE_01 - Command 0x88 returns newest input voltage L11 word, same on every page.
// RULE_02 - Command 0x89 returns newest input current, scaled by the range field.
// RULE_03 - Command 0x97 returns input current times input voltage, in watts.
// RULE_04 - Command 0x8B returns selected channel's newest output voltage, L16.
// RULE_05 - Command 0x8C returns selected channel's newest output current, L11.
// RULE_06 - Bad external diode reading: junction temperature replaces it everywhere.
// RULE_07 - Junction temperature word is informational; affects nothing unless substituted.
// RULE_08 - Command 0x96 returns selected channel's newest computed output power.
// RULE_09 - Command 0xBB is signed count with 2.5 mA per step.
// RULE_10 - Alternate current word saturates at 81.92 A magnitude.
// RULE_11 - Sense word is unsigned count, LSB 0.025 or 0.75 times 2^-13.
// RULE_12 - Command 0xFA holds magnitude of raw sense differential, uncompensated.
// RULE_13 - Input current peak preloads 0x7C00 on reset, any clear, channel on.
// RULE_14 - Input current minimum preloads 0x7BFF on reset, any clear, channel on.
// RULE_15 - Input power peak preloads 0x7C00 on reset, any clear, channel on.
// RULE_16 - Input power minimum preloads 0x7BFF on reset, any clear, channel on.
// RULE_17 - Input voltage peak preloads 0x7C00 on reset, any clear, channel on.
// RULE_18 - Input voltage minimum preloads 0x7BFF on reset, any clear, channel on.
// RULE_19 - Output voltage peak preloads 0xF800 on reset, page clear, own turn-on.
// RULE_20 - Output current peak preloads 0x7C00 on reset, page clear, own turn-on.
// RULE_21 - Temperature peak preloads 0x7C00 on reset, page clear, own turn-on.
// RULE_22 - Output voltage minimum preloads 0xFFFF on reset, page clear, own turn-on.
// RULE_23 - Output current minimum preloads 0x7BFF on reset, page clear, own turn-on.
// RULE_24 - Trackers replace on larger or smaller decoded value after each conversion.
// RULE_25 - Host selects page first and only reads words.
package tpm_pkg;
  localparam int NUM_CH = 2;
  localparam logic [7:0] CMD_VIN = 8'h88;
  localparam logic [7:0] CMD_IIN = 8'h89;
  localparam logic [7:0] CMD_VOUT = 8'h8b;
  localparam logic [7:0] CMD_IOUT = 8'h8c;
  localparam logic [7:0] CMD_TEXT = 8'h8d;
  localparam logic [7:0] CMD_TINT = 8'h8e;
  localparam logic [7:0] CMD_POUT = 8'h96;
  localparam logic [7:0] CMD_PIN = 8'h97;
  localparam logic [7:0] CMD_IOUT_FINE = 8'hbb;
  localparam logic [7:0] CMD_IIN_MAX = 8'hc4;
  localparam logic [7:0] CMD_IIN_LOW = 8'hc5;
  localparam logic [7:0] CMD_PIN_MAX = 8'hc6;
  localparam logic [7:0] CMD_PIN_LOW = 8'hc7;
  localparam logic [7:0] CMD_IOUT_MAX = 8'hd7;
  localparam logic [7:0] CMD_IOUT_LOW = 8'hd8;
  localparam logic [7:0] CMD_VOUT_MAX = 8'hdd;
  localparam logic [7:0] CMD_VIN_MAX = 8'hde;
  localparam logic [7:0] CMD_TEXT_MAX = 8'hdf;
  localparam logic [7:0] CMD_SENSE = 8'hfa;
  localparam logic [7:0] CMD_VOUT_LOW = 8'hfb;
  localparam logic [7:0] CMD_VIN_LOW = 8'hfc;
  localparam logic [7:0] CMD_TEXT_LOW = 8'hfd;
  localparam logic [7:0] PAGE_ALL = 8'hff;
  localparam logic [15:0] L11_MAX_RST = 16'h7c00;
  localparam logic [15:0] L11_LOW_RST = 16'h7bff;
  localparam logic [15:0] L16_MAX_RST = 16'hf800;
  localparam logic [15:0] L16_LOW_RST = 16'hffff;
  // Exponent field of a linear-11 word sits above the 11-bit mantissa.
  localparam int L11_EXP_LSB = 11;
  localparam logic signed [7:0] VOUT_EXP = -8'sd13;
  // Alternate current counts per amp: one count is 2.5 mA.
  localparam logic signed [47:0] FINE_PER_AMP = 48'sd400;
  localparam logic signed [47:0] FINE_POS = 48'sd32767;
  localparam logic signed [47:0] FINE_NEG = -48'sd32768;
endpackage : tpm_pkg
